// *** bench/semp_mem_model.sv ***
`timescale 1ns/1ps
module semp_mem_model (
    // memory clock and pins
    input wire logic mclk,
    input wire logic [3:0] sel_n,
    input wire logic pa,
    input wire logic pb,
    input wire logic pc,
    // setup from bench
    input wire logic [1:0] lat,
    input wire logic [31:0] pat,
    // read data
    output logic [31:0] dq
);
    int cnt = 7;
    int tgt = 0;
    logic prev = 1'b0;
    logic cmd;
    initial dq = 32'h0;
    // read: strobe low, write strobe high
    assign cmd = (sel_n != 4'hf) && !pa && pc;
    always @(posedge mclk) begin
        if (cmd && !prev) begin
            cnt = 0;
            tgt = pb ? 3 : lat + 1;
        end else if (cnt < 7) begin
            cnt = cnt + 1;
        end
        prev <= cmd;
        if (cnt == tgt - 1) dq <= pat;
    end
    // outside the valid window the bus wanders
    always @(negedge mclk) begin
        if (cnt != tgt - 1) dq <= ~dq;
    end
endmodule : semp_mem_model

// *** bench/sync_ext_memory_port_test.sv ***
`timescale 1ns/1ps
module sync_ext_memory_port_test;
    import semp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic link_clk_in = 1'b0;
    logic [3:0] av_a = 4'h0;
    logic av_r = 1'b0;
    logic av_w = 1'b0;
    logic [31:0] av_d = 32'h0;
    logic [31:0] av_q, md_i, md_o, wd_seen, dmy;
    logic [31:0] pat = 32'h0;
    logic wq, ck1, ck2, pa, pb, pc, cke, oe;
    logic sel2 = 1'b0;
    logic seen = 1'b1;
    logic ext_on = 1'b0;
    logic [1:0] lat = 2'h0;
    logic [3:0] sel_n, ln_n, c_sel, c_ln;
    logic [19:0] wa, c_addr;
    logic [2:0] c_pins;
    int num_errors = 0;
    int total_checks = 0;
    int ext_bad = 0;

    always #20 clk = ~clk;
    initial begin
        #7;
        forever #160 link_clk_in = ~link_clk_in;
    end

    semp_port #(.DIV2(3'h2)) uut (.clk(clk), .sys_rst(sys_rst), .avs_address(av_a),
        .avs_read(av_r), .avs_write(av_w), .avs_writedata(av_d), .avs_readdata(av_q),
        .avs_waitrequest(wq), .link_clk_in(link_clk_in), .mem_clk_out_first(ck1),
        .mem_clk_out_second(ck2), .space_select_n(sel_n), .byte_lane_n(ln_n),
        .word_addr(wa), .shared_strobe_pin_a(pa), .shared_strobe_pin_b(pb),
        .shared_strobe_pin_c(pc), .dram_clk_en(cke), .mem_data_i(md_i),
        .mem_data_o(md_o), .mem_data_oe(oe));

    semp_mem_model mem (.mclk(sel2 ? ck2 : ck1), .sel_n(sel_n), .pa(pa), .pb(pb),
        .pc(pc), .lat(lat), .pat(pat), .dq(md_i));

    // first command cycle of each access, write data, select gaps
    always @(posedge clk) begin
        if (!seen && sel_n !== 4'hf) begin
            seen <= 1'b1;
            c_pins <= {pa, pb, pc};
            c_addr <= wa;
            c_ln <= ln_n;
            c_sel <= sel_n;
        end
        if (oe === 1'b1) wd_seen <= md_o;
        if (ext_on && pb === 1'b0 && sel_n === 4'hf) ext_bad++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge clk);
        av_a <= a;
        av_w <= w;
        av_r <= ~w;
        av_d <= d;
        do begin
            @(posedge clk);
        end while (wq !== 1'b0);
        q = av_q;
        av_w <= 1'b0;
        av_r <= 1'b0;
    endtask : bus

    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, dmy);
    endtask : wr

    task rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    task idle;
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 300 && s[0] !== 1'b0; i++) begin
            rd(4'h7, s);
        end
        chk(s[0], 1'b0);
    endtask : idle

    // address, then command with lanes 0 and 2
    task op(input logic [3:0] code, input logic [1:0] sp, input logic [19:0] ad);
        wr(4'h4, {12'h0, ad});
        @(posedge clk);
        seen <= 1'b0;
        wr(4'h6, {22'h0, 4'h5, sp, code});
        idle;
    endtask : op

    task t_reset;
        logic [31:0] q;
        chk({sel_n, ln_n, pa, pb, pc, oe, cke}, {8'hff, 5'h1d});
        for (int s = 0; s < 10; s++) begin
            if (s < 4 || s == 6 || s == 9) begin
                rd(s[3:0], q);
                chk(q, 32'h0);
            end
        end
        $display("reset test done");
    endtask : t_reset

    task t_rd_lat;
        logic [31:0] q;
        for (int l = 0; l < 4; l++) begin
            wr(4'h0, {30'h0, l[1:0]});
            lat <= l[1:0];
            pat <= {16'hc0de, 14'h0, l[1:0]};
            op(4'h0, 2'h0, 20'h0a5a5);
            rd(4'h7, q);
            chk(q[1], 1'b1);
            rd(4'h8, q);
            chk(q, {16'hc0de, 14'h0, l[1:0]});
            chk({c_pins, c_ln, c_sel}, {3'h1, 4'ha, 4'he});
            chk(c_addr, 20'h0a5a5);
            chk(sel_n, 4'hf);
        end
        $display("read latency test done");
    endtask : t_rd_lat

    task t_rd_fifo;
        logic [31:0] q;
        wr(4'h0, 32'h3);
        wr(4'h2, 32'h71);
        sel2 <= 1'b1;
        lat <= 2'h1;
        pat <= 32'h5a5a1234;
        ext_bad = 0;
        ext_on <= 1'b1;
        op(4'h0, 2'h2, 20'h00777);
        ext_on <= 1'b0;
        rd(4'h8, q);
        chk(q, 32'h5a5a1234);
        chk(c_sel, 4'hb);
        chk(ext_bad, 32'h0);
        chk(sel_n, 4'hf);
        wr(4'h5, 32'h600d0002);
        op(4'h1, 2'h2, 20'h00778);
        chk(wd_seen, 32'h600d0002);
        chk({oe, sel_n}, 5'h0f);
        sel2 <= 1'b0;
        $display("fifo read test done");
    endtask : t_rd_fifo

    task t_wr_lat;
        for (int l = 0; l < 4; l++) begin
            wr(4'h1, {28'h0, l[1:0], 2'h0});
            wr(4'h5, {16'hbeef, 14'h0, l[1:0]});
            op(4'h1, 2'h1, 20'h00100);
            chk(wd_seen, {16'hbeef, 14'h0, l[1:0]});
            chk({c_pins[1:0], c_sel}, {2'h2, 4'hd});
            chk({oe, sel_n}, 5'h0f);
        end
        $display("write latency test done");
    endtask : t_wr_lat

    task t_sdram;
        logic [31:0] q;
        logic [2:0] pins [0:6];
        pins = '{3'h3, 3'h2, 3'h5, 3'h4, 3'h4, 3'h1, 3'h0};
        wr(4'h3, 32'h40);
        wr(4'h5, 32'h5d5d0001);
        pat <= 32'h0d0e0f10;
        for (int k = 0; k < 7; k++) begin
            op(k[3:0] + 4'h2, 2'h3, 20'h00abc);
            chk(c_pins, pins[k]);
            if (k == 1) chk(wd_seen, 32'h5d5d0001);
            if (k == 0) begin
                rd(4'h8, q);
                chk(q, 32'h0d0e0f10);
            end
            if (k == 3 || k == 4) chk(c_addr[10], k == 4);
            if (k == 6) chk(c_addr, 20'h00abc);
        end
        $display("sdram command test done");
    endtask : t_sdram

    task t_selfref;
        logic [31:0] q;
        op(4'h9, 2'h3, 20'h0);
        rd(4'h7, q);
        chk({q[2], cke}, 2'h2);
        wr(4'h6, 32'h0);
        rd(4'h7, q);
        chk(q[2:0], 3'h4);
        op(4'ha, 2'h3, 20'h0);
        rd(4'h7, q);
        chk({q[2], cke}, 2'h1);
        wr(4'h6, 32'h14b);
        rd(4'h7, q);
        chk(q[0], 1'b0);
        $display("self refresh test done");
    endtask : t_selfref

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_rd_lat;
        t_rd_fifo;
        t_wr_lat;
        t_sdram;
        t_selfref;
        finish_test;
    end

    initial begin
        #2000000;
        num_errors++;
        $display("watchdog expired");
        finish_test;
    end
endmodule : sync_ext_memory_port_test

// *** shared/semp_pkg.sv ***
package semp_pkg;
    // register byte offsets
    localparam logic [5:0] REG_CFG0 = 6'h00;
    localparam logic [5:0] REG_CFG3 = 6'h0c;
    localparam logic [5:0] REG_ADDR = 6'h10;
    localparam logic [5:0] REG_WDATA = 6'h14;
    localparam logic [5:0] REG_CMD = 6'h18;
    localparam logic [5:0] REG_STATUS = 6'h1c;
    localparam logic [5:0] REG_RDATA = 6'h20;
    // per-space config fields
    localparam int CFG_RL_LSB = 0;
    localparam int CFG_WL_LSB = 2;
    localparam int CFG_SELECT_EXTEND_BIT = 4;
    localparam int CFG_READ_ENABLE_MODE_BIT = 5;
    localparam int CFG_CLKSEL_BIT = 6;
    localparam logic [7:0] CFG_RST = 8'h00;
    // command fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SPACE_LSB = 4;
    localparam int CMD_LANE_LSB = 6;
    // status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RDV_BIT = 1;
    localparam int ST_SR_BIT = 2;
    // widths and timing
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int SPACES = 4;
    localparam logic [2:0] CAS_LAT = 3'h3;
    localparam int PRE_ALL_BIT = 10;
    localparam logic [2:0] DIV2_DEF = 3'h2;

    typedef enum logic [3:0] {
        OP_SYNC_RD, OP_SYNC_WR, OP_SD_RD, OP_SD_WR, OP_BANK_ACTIVATE_CMD, OP_CLOSE, OP_CLOSE_ALL,
        OP_REFRESH, OP_MODE_SET, OP_SR_ENTER, OP_SR_EXIT
    } semp_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DESEL} semp_state_t;
endpackage : semp_pkg

// *** src/semp_clk_gen.sv ***
`timescale 1ns/1ps
module semp_clk_gen #(
    parameter logic [2:0] DIV2 = semp_pkg::DIV2_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link clock input
    input wire logic link_clk_in,
    // memory output clocks and their rising ticks
    output logic mem_clk_out_first,
    output logic mem_clk_out_second,
    output logic rise_first,
    output logic rise_second
);
    import semp_pkg::*;

    typedef struct packed {
        logic [2:0] sync;
        logic lvl;
        logic [2:0] cnt;
        logic clk2;
        logic r1;
        logic r2;
    } semp_cg_t;

    semp_cg_t r_reg, r_next;

    if (DIV2 == 3'h0) begin : g_div_check
        $error("second clock divider must be 1 to 7");
    end

    always_comb begin
        r_next = r_reg;
        r_next.sync = {r_reg.sync[1:0], link_clk_in};
        r_next.r1 = 1'b0;
        r_next.r2 = 1'b0;
        // edge counts once the second and third stage agree
        if (r_reg.sync[1] == r_reg.sync[2] && r_reg.sync[2] != r_reg.lvl) begin
            r_next.lvl = r_reg.sync[2];
            r_next.r1 = r_reg.sync[2];
            if (r_reg.cnt == DIV2 - 3'h1) begin
                r_next.cnt = 3'h0;
                r_next.clk2 = ~r_reg.clk2;
                r_next.r2 = ~r_reg.clk2;
            end else begin
                r_next.cnt = r_reg.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign mem_clk_out_first = r_reg.lvl;
    assign mem_clk_out_second = r_reg.clk2;
    assign rise_first = r_reg.r1;
    assign rise_second = r_reg.r2;
endmodule : semp_clk_gen

// *** src/semp_port.sv ***
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module semp_port #(
    parameter logic [2:0] DIV2 = semp_pkg::DIV2_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [semp_pkg::DATA_W-1:0] avs_writedata,
    output logic [semp_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // link clock in, memory clocks out
    input wire logic link_clk_in,
    output logic mem_clk_out_first,
    output logic mem_clk_out_second,
    // memory pins
    output logic [semp_pkg::SPACES-1:0] space_select_n,
    output logic [3:0] byte_lane_n,
    output logic [semp_pkg::ADDR_W-1:0] word_addr,
    output logic shared_strobe_pin_a,
    output logic shared_strobe_pin_b,
    output logic shared_strobe_pin_c,
    output logic dram_clk_en,
    input wire logic [semp_pkg::DATA_W-1:0] mem_data_i,
    output logic [semp_pkg::DATA_W-1:0] mem_data_o,
    output logic mem_data_oe
);
    import semp_pkg::*;

    typedef struct packed {
        semp_state_t st;
        logic [2:0] cnt;
        logic busy;
        logic rd_ack;
        logic rd_valid;
        logic sr_active;
        semp_op_t op;
        logic [1:0] space;
        logic [3:0] lanes;
        logic [SPACES-1:0][7:0] cfg;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] rdout;
        logic [SPACES-1:0] cs_n;
        logic [3:0] lane_n;
        logic [ADDR_W-1:0] wa;
        logic [DATA_W-1:0] dout;
        logic dout_oe;
        logic pa;
        logic pb;
        logic pc;
        logic cke;
    } semp_st_t;

    semp_st_t r_reg, r_next;
    logic rise_first, rise_second;
    logic tick;
    logic is_sd;
    logic [7:0] cur_cfg;
    logic [1:0] rl_cur, wl_cur;
    logic cee_cur, ren_cur;
    logic [5:0] byte_addr;
    logic cmd_hit;
    logic [SPACES-1:0] sel_n;

    semp_clk_gen #(.DIV2(DIV2)) u_clk (
        .clk(clk),
        .sys_rst(sys_rst),
        .link_clk_in(link_clk_in),
        .mem_clk_out_first(mem_clk_out_first),
        .mem_clk_out_second(mem_clk_out_second),
        .rise_first(rise_first),
        .rise_second(rise_second)
    );

    assign byte_addr = {avs_address, 2'b00};
    assign cmd_hit = avs_write && byte_addr == REG_CMD;
    assign cur_cfg = r_reg.cfg[r_reg.space];
    assign rl_cur = cur_cfg[CFG_RL_LSB +: 2];
    assign wl_cur = cur_cfg[CFG_WL_LSB +: 2];
    assign cee_cur = cur_cfg[CFG_SELECT_EXTEND_BIT];
    assign ren_cur = cur_cfg[CFG_READ_ENABLE_MODE_BIT];
    assign is_sd = r_reg.op != OP_SYNC_RD && r_reg.op != OP_SYNC_WR;
    // sdram on first clock, sync space on its chosen clock
    assign tick = (is_sd || !cur_cfg[CFG_CLKSEL_BIT]) ? rise_first : rise_second;
    assign sel_n = ~(SPACES'(1) << r_reg.space);
    // stall a command while busy, reads for one registered cycle
    assign avs_waitrequest = (avs_read && !r_reg.rd_ack) || (cmd_hit && r_reg.busy);

    function automatic logic [DATA_W-1:0] reg_read(input semp_st_t s, input logic [5:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        if (a <= REG_CFG3) begin
            v[7:0] = s.cfg[a[3:2]];
        end else if (a == REG_ADDR) begin
            v[ADDR_W-1:0] = s.addr;
        end else if (a == REG_WDATA) begin
            v = s.wdata;
        end else if (a == REG_STATUS) begin
            v[ST_BUSY_BIT] = s.busy;
            v[ST_RDV_BIT] = s.rd_valid;
            v[ST_SR_BIT] = s.sr_active;
        end else if (a == REG_RDATA) begin
            v = s.rdata;
        end
        return v;
    endfunction : reg_read

    // back to idle pin levels
    function automatic semp_st_t release_pins(input semp_st_t s);
        semp_st_t o;
        o = s;
        o.cs_n = '1;
        o.lane_n = '1;
        o.pa = 1'b1;
        o.pb = 1'b1;
        o.pc = 1'b1;
        o.dout_oe = 1'b0;
        return o;
    endfunction : release_pins

    always_comb begin
        semp_op_t new_op;
        new_op = semp_op_t'(avs_writedata[CMD_OP_LSB +: 4]);
        r_next = r_reg;
        // register bus
        if (r_reg.rd_ack) begin
            r_next.rd_ack = 1'b0;
        end else if (avs_read) begin
            r_next.rd_ack = 1'b1;
            r_next.rdout = reg_read(r_reg, byte_addr);
        end
        if (avs_write) begin
            if (byte_addr <= REG_CFG3) begin
                r_next.cfg[avs_address[1:0]] = avs_writedata[7:0];
            end else if (byte_addr == REG_ADDR) begin
                r_next.addr = avs_writedata[ADDR_W-1:0];
            end else if (byte_addr == REG_WDATA) begin
                r_next.wdata = avs_writedata;
            end else if (cmd_hit && !r_reg.busy && avs_writedata[CMD_OP_LSB +: 4] <= 4'ha) begin
                // in self-refresh only the exit command is taken
                if (r_reg.sr_active == (new_op == OP_SR_EXIT)) begin
                    r_next.busy = 1'b1;
                    r_next.rd_valid = 1'b0;
                    r_next.op = new_op;
                    r_next.space = avs_writedata[CMD_SPACE_LSB +: 2];
                    r_next.lanes = avs_writedata[CMD_LANE_LSB +: 4];
                end
            end
        end
        // pin sequencer, advances only on tick: the first clock for sdram, the space's chosen clock for sync
        if (tick) begin
            unique case (r_reg.st)
                ST_IDLE: begin
                    if (r_reg.busy) begin
                        r_next.st = ST_WAIT;
                        r_next.cnt = 3'h0;
                        r_next.cs_n = sel_n;
                        r_next.wa = r_reg.addr;
                        r_next.dout = r_reg.wdata;
                        r_next.lane_n = ~r_reg.lanes;
                        unique case (r_reg.op)
                            OP_SYNC_RD: begin
                                r_next.pa = 1'b0;
                                r_next.pb = 1'b0;
                            end
                            OP_SYNC_WR: begin
                                r_next.pc = 1'b0;
                                r_next.dout_oe = wl_cur == 2'h0;
                                if (cee_cur) begin
                                    r_next.cs_n = '1;
                                end
                            end
                            OP_SD_RD: begin
                                r_next.pa = 1'b0;
                            end
                            OP_SD_WR: begin
                                r_next.pa = 1'b0;
                                r_next.pc = 1'b0;
                                r_next.dout_oe = 1'b1;
                            end
                            OP_BANK_ACTIVATE_CMD: begin
                                r_next.pb = 1'b0;
                            end
                            OP_CLOSE, OP_CLOSE_ALL: begin
                                r_next.pb = 1'b0;
                                r_next.pc = 1'b0;
                                r_next.wa[PRE_ALL_BIT] = r_reg.op == OP_CLOSE_ALL;
                            end
                            OP_REFRESH, OP_SR_ENTER: begin
                                r_next.pa = 1'b0;
                                r_next.pb = 1'b0;
                                r_next.cke = r_reg.op != OP_SR_ENTER;
                            end
                            OP_MODE_SET: begin
                                r_next.pa = 1'b0;
                                r_next.pb = 1'b0;
                                r_next.pc = 1'b0;
                            end
                            OP_SR_EXIT: begin
                                r_next.cs_n = '1;
                                r_next.cke = 1'b1;
                                r_next.sr_active = 1'b0;
                            end
                        endcase
                    end
                end
                ST_WAIT: begin
                    r_next.cnt = r_reg.cnt + 3'h1;
                    unique case (r_reg.op)
                        OP_SYNC_RD: begin
                            r_next.pa = 1'b1;
                            // select drops after command unless extended
                            r_next.cs_n = cee_cur ? r_reg.cs_n : '1;
                            if (r_reg.cnt == {1'b0, rl_cur}) begin
                                r_next = release_pins(r_next);
                                r_next.rdata = mem_data_i;
                                r_next.rd_valid = 1'b1;
                                r_next.st = ren_cur ? ST_IDLE : ST_DESEL;
                                r_next.busy = !ren_cur;
                            end
                        end
                        OP_SYNC_WR: begin
                            r_next.pc = 1'b1;
                            r_next.cs_n = '1;
                            if (r_reg.dout_oe) begin
                                r_next = release_pins(r_next);
                                r_next.st = ren_cur ? ST_IDLE : ST_DESEL;
                                r_next.busy = !ren_cur;
                            end else if (r_reg.cnt + 3'h1 == {1'b0, wl_cur}) begin
                                r_next.dout_oe = 1'b1;
                            end
                        end
                        OP_SD_RD: begin
                            r_next = release_pins(r_next);
                            if (r_reg.cnt == CAS_LAT - 3'h1) begin
                                r_next.rdata = mem_data_i;
                                r_next.rd_valid = 1'b1;
                                r_next.st = ST_IDLE;
                                r_next.busy = 1'b0;
                            end
                        end
                        default: begin
                            r_next = release_pins(r_next);
                            r_next.st = ST_IDLE;
                            r_next.busy = 1'b0;
                            if (r_reg.op == OP_SR_ENTER) begin
                                r_next.sr_active = 1'b1;
                            end else if (r_reg.op == OP_SR_EXIT) begin
                                r_next.sr_active = 1'b0;
                            end
                        end
                    endcase
                end
                ST_DESEL: begin
                    r_next.st = ST_IDLE;
                    r_next.busy = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.op <= OP_SYNC_RD;
            r_reg.cfg <= {SPACES{CFG_RST}};
            r_reg.cs_n <= '1;
            r_reg.lane_n <= '1;
            r_reg.pa <= 1'b1;
            r_reg.pb <= 1'b1;
            r_reg.pc <= 1'b1;
            r_reg.cke <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign avs_readdata = r_reg.rdout;
    assign space_select_n = r_reg.cs_n;
    assign byte_lane_n = r_reg.lane_n;
    assign word_addr = r_reg.wa;
    assign shared_strobe_pin_a = r_reg.pa;
    assign shared_strobe_pin_b = r_reg.pb;
    assign shared_strobe_pin_c = r_reg.pc;
    assign dram_clk_en = r_reg.cke;
    assign mem_data_o = r_reg.dout;
    assign mem_data_oe = r_reg.dout_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic pins_moved;
    assign pins_moved = r_reg.busy && (r_next.pa != r_reg.pa || r_next.pb != r_reg.pb
        || r_next.pc != r_reg.pc || r_next.cs_n != r_reg.cs_n);

    a_sync_rd_latency: assert property ($rose(r_reg.rd_valid) && r_reg.op == OP_SYNC_RD
        |-> $past(r_reg.cnt) == {1'b0, $past(rl_cur)})
        else $error("sync read captured at wrong latency");
    a_sync_wr_latency: assert property ($rose(r_reg.dout_oe) && r_reg.op == OP_SYNC_WR
        && $past(r_reg.st) == ST_WAIT |-> $past(r_reg.cnt) + 3'h1 == {1'b0, wl_cur})
        else $error("sync write data at wrong latency");
    a_select_release: assert property (r_reg.st == ST_WAIT && r_reg.op == OP_SYNC_RD
        && !cee_cur && tick |=> &r_reg.cs_n)
        else $error("select held after command");
    a_select_extend: assert property (r_reg.st == ST_WAIT && r_reg.op == OP_SYNC_RD
        && cee_cur |-> (r_reg.cs_n != '1) == !r_reg.pb)
        else $error("select not following output enable");
    a_deselect_mode: assert property (r_reg.st == ST_DESEL |-> !ren_cur && &r_reg.cs_n
        && r_reg.pa)
        else $error("deselect cycle in fifo mode or pins active");
    a_sync_clock: assert property (pins_moved && !is_sd |-> tick
        && (cur_cfg[CFG_CLKSEL_BIT] ? rise_second : rise_first))
        else $error("sync pins moved off selected clock");
    a_sdram_clock: assert property (pins_moved && is_sd |-> rise_first)
        else $error("sdram pins moved off first clock");
    a_cas_latency: assert property ($rose(r_reg.rd_valid) && r_reg.op == OP_SD_RD
        |-> $past(r_reg.cnt) == CAS_LAT - 3'h1)
        else $error("sdram read not at cas latency three");
    a_mode_value: assert property (r_reg.st == ST_WAIT && $past(r_reg.st) == ST_IDLE
        && r_reg.op == OP_MODE_SET |-> r_reg.wa == r_reg.addr && !r_reg.pa && !r_reg.pb
        && !r_reg.pc && r_reg.cs_n != '1)
        else $error("mode-set command malformed");
    a_self_refresh: assert property (r_reg.sr_active |-> !r_reg.cke)
        else $error("clock enable high in self-refresh");

    c_sync_read: cover property ($rose(r_reg.rd_valid) && r_reg.op == OP_SYNC_RD);
    c_fifo_write: cover property (r_reg.op == OP_SYNC_WR && ren_cur && $fell(r_reg.busy));
    c_sdram_read: cover property ($rose(r_reg.rd_valid) && r_reg.op == OP_SD_RD);
    c_self_refresh: cover property ($fell(r_reg.sr_active));
endmodule : semp_port
